//--- rtl/cbc_pkg.sv
// Package for the cache and bus control register bank
package cbc_pkg;
  // Register byte addresses
  localparam logic [3:0] CBC_CTL_ADDR  = 4'h0;
  localparam logic [3:0] CBC_WAYD_ADDR = 4'h4;
  localparam logic [3:0] CBC_PID_ADDR  = 4'h8;
  // Bit positions, LSB numbering (MSB-first bit k sits at 31-k)
  localparam int CBC_CLK_LSB       = 21;
  localparam int CBC_CLK_W         = 5;
  localparam int CBC_CACHE_OFF_BIT = 20;
  localparam int CBC_BAR_OFF_BIT   = 16;
  localparam int CBC_IO_OFF_BIT    = 15;
  localparam int CBC_XLAT_OFF_BIT  = 14;
  localparam int CBC_STROBE_BIT    = 13;
  localparam int CBC_ICACHE_BIT    = 12;
  localparam int CBC_DCACHE_BIT    = 11;
  localparam int CBC_L2_EN_BIT     = 10;
  localparam int CBC_IPF_BIT       = 7;
  localparam int CBC_DPF_BIT       = 5;
  localparam int CBC_MASK_UPD_BIT  = 4;
  localparam int CBC_TAG_UPD_BIT   = 3;
  localparam int CBC_ICOH_BIT      = 0;
  // Writable bits of the control register
  localparam logic [31:0] CBC_CTL_WMASK = 32'h0011_fcb9;
  localparam logic [31:0] CBC_CTL_RESET = 32'h0000_0000;
  localparam int          CBC_WAYS      = 8;
  localparam logic [7:0]  CBC_WAYD_RESET = 8'h00;
  localparam logic [31:0] CBC_PID_RESET = 32'h0000_0000;
  localparam int          CBC_WAY_LIMIT = 4;
  // AXI responses
  localparam logic [1:0]  CBC_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  CBC_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    CBC_W_IDLE = 2'h1,
    CBC_W_RESP = 2'h2
  } cbc_wstate_t;
endpackage : cbc_pkg

//--- rtl/cbc_wr_if.sv
// Write strobe carrier between bus slave and register bank
`timescale 1ns/10ps
interface cbc_wr_if;
  logic        wen;
  logic [3:0]  addr;
  logic [31:0] data;
  logic [3:0]  strb;
  modport src (output wen, output addr, output data, output strb);
  modport dst (input wen, input addr, input data, input strb);
endinterface : cbc_wr_if

//--- rtl/cbc_way_cell.sv
// One level 2 way disable bit with guarded update
`timescale 1ns/10ps
module cbc_way_cell (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic load,
  input  wire logic din,
  output logic      q
);
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q <= 1'b0;
    end else if (load) begin
      q <= din;
    end
  end
endmodule : cbc_way_cell

//--- rtl/cbc_regs.sv
// Cache and bus control register bank with AXI4-Lite slave
// How it works
// - Clock ratio field loads from config pins at hard reset; writes ignored.
// - Cache op broadcast and snooping run only while off bit is clear.
// - Block-zero kills broadcast regardless of cache broadcast bit.
// - Barriers broadcast unless off bit set; then complete locally.
// - IO ordering instructions broadcast only while off bit clear.
// - Translation ops broadcast unless off bit; sync then completes locally.
// - Strobe pin follows strobe bit; breakpoint may invert one bus cycle.
// - Instruction cache bypassed and unfilled while its enable is clear.
// - Data cache bypassed and unfilled while its enable is clear.
// - Level 2 disabled sends both-miss accesses off chip.
// - Instruction prefetch allowed only while its enable is set.
// - Data prefetch allowed only while its enable is set.
// - Way disable writes accepted only while mask update enable set.
// - Diagnostic block-valid updates allowed only while tag update set.
// - Instruction coherency with stores kept while coherency bit set.
// - Eight way disable bits; set bit removes that way everywhere.
// - Over four ways disabled with level 2 on may raise checks.
// - Processor identifier is 32-bit storage never used by hardware.
`timescale 1ns/10ps
module cbc_regs
  import cbc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        hard_reset,
  input  wire logic [4:0]  clock_cfg_pins,
  input  wire logic        bus_clk_edge,
  input  wire logic        brk_strobe_invert,
  input  wire logic        blockzero_kill_req,
  input  wire logic        cache_op_req,
  input  wire logic        snoop_in_req,
  input  wire logic        barrier_req,
  input  wire logic        io_order_req,
  input  wire logic        tlb_op_req,
  input  wire logic        tlb_sync_req,
  input  wire logic        diag_use_wr,
  input  wire logic        ifetch_miss,
  input  wire logic        data_miss,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             strobe_pin,
  output logic             bus_broadcast_cache_op,
  output logic             bus_broadcast_kill_bz,
  output logic             snoop_respond,
  output logic             bus_broadcast_barrier,
  output logic             barrier_local_done,
  output logic             bus_broadcast_io_order,
  output logic             bus_broadcast_tlb,
  output logic             tlb_sync_local_done,
  output logic             icache_use,
  output logic             icache_fill_allow,
  output logic             dcache_use,
  output logic             dcache_fill_allow,
  output logic             level2_use,
  output logic             instr_prefetch_go,
  output logic             data_prefetch_go,
  output logic             block_valid_wr_allow,
  output logic             instr_coherency_on,
  output logic [7:0]       way_disable,
  output logic             way_check_risk
);
  cbc_wr_if wr ();

  logic [31:0]     ctl_reg;
  logic [4:0]      clock_ratio_reg;
  logic [31:0]     pid_reg;
  logic [31:0]     ctl_view;
  logic [31:0]     ctl_next;
  logic [31:0]     bmask;
  cbc_wstate_t     wstate_reg;
  logic            aw_have_reg;
  logic            w_have_reg;
  logic [3:0]      awaddr_reg;
  logic [31:0]     wdata_reg;
  logic [3:0]      wstrb_reg;
  logic            aw_bad_reg;
  logic [1:0]      bresp_reg;
  logic            strobe_flip_reg;
  logic            way_load;
  logic [3:0]      way_count;

  // Byte lane mask from strobes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      bmask[i*8 +: 8] = {8{wr.strb[i]}};
    end
  end

  // AXI write path: take address and data in either order
  assign s_axi_awready = (wstate_reg == CBC_W_IDLE) && !aw_have_reg;
  assign s_axi_wready  = (wstate_reg == CBC_W_IDLE) && !w_have_reg;
  assign s_axi_bvalid  = (wstate_reg == CBC_W_RESP);
  assign s_axi_bresp   = bresp_reg;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      aw_have_reg <= 1'b0;
      awaddr_reg  <= 4'h0;
      aw_bad_reg  <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr[3:0];
      aw_bad_reg  <= (s_axi_awaddr[31:4] != 28'h0) ||
                     (s_axi_awaddr[3:0] != CBC_CTL_ADDR &&
                      s_axi_awaddr[3:0] != CBC_WAYD_ADDR &&
                      s_axi_awaddr[3:0] != CBC_PID_ADDR);
    end else if (wr.wen) begin
      aw_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      w_have_reg <= 1'b0;
      wdata_reg  <= 32'h0;
      wstrb_reg  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end else if (wr.wen) begin
      w_have_reg <= 1'b0;
    end
  end

  assign wr.wen  = (wstate_reg == CBC_W_IDLE) && aw_have_reg && w_have_reg;
  assign wr.addr = aw_bad_reg ? 4'hf : awaddr_reg;
  assign wr.data = wdata_reg;
  assign wr.strb = wstrb_reg;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wstate_reg <= CBC_W_IDLE;
      bresp_reg  <= CBC_RESP_OKAY;
    end else begin
      case (wstate_reg)
        CBC_W_IDLE: begin
          if (wr.wen) begin
            wstate_reg <= CBC_W_RESP;
            bresp_reg  <= aw_bad_reg ? CBC_RESP_SLVERR : CBC_RESP_OKAY;
          end
        end
        CBC_W_RESP: begin
          if (s_axi_bready) begin
            wstate_reg <= CBC_W_IDLE;
          end
        end
        default: wstate_reg <= CBC_W_IDLE;
      endcase
    end
  end

  // Control register: only defined bits store
  assign ctl_next = (ctl_reg & ~(bmask & CBC_CTL_WMASK)) |
                    (wr.data & bmask & CBC_CTL_WMASK);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctl_reg <= CBC_CTL_RESET;
    end else if (wr.wen && wr.addr == CBC_CTL_ADDR) begin
      ctl_reg <= ctl_next;
    end
  end

  // Clock ratio captured from pins on hard reset only
  always_ff @(posedge clk_sys) begin
    if (hard_reset) begin
      clock_ratio_reg <= clock_cfg_pins;
    end
  end

  always_comb begin
    ctl_view = ctl_reg;
    ctl_view[CBC_CLK_LSB +: CBC_CLK_W] = clock_ratio_reg;
  end

  // Way disable bits, guarded by mask update enable
  assign way_load = wr.wen && wr.addr == CBC_WAYD_ADDR && wr.strb[0] &&
                    ctl_reg[CBC_MASK_UPD_BIT];

  genvar g;
  generate
    for (g = 0; g < CBC_WAYS; g++) begin : g_way
      cbc_way_cell u_cell (
        .clk_sys (clk_sys),
        .reset   (reset),
        .load    (way_load),
        .din     (wr.data[g]),
        .q       (way_disable[g])
      );
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pid_reg <= CBC_PID_RESET;
    end else if (wr.wen && wr.addr == CBC_PID_ADDR) begin
      pid_reg <= (pid_reg & ~bmask) | (wr.data & bmask);
    end
  end

  // AXI read path, one outstanding read
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= CBC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= CBC_RESP_OKAY;
      if (s_axi_araddr[31:4] != 28'h0) begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= CBC_RESP_SLVERR;
      end else if (s_axi_araddr[3:0] == CBC_CTL_ADDR) begin
        s_axi_rdata <= ctl_view;
      end else if (s_axi_araddr[3:0] == CBC_WAYD_ADDR) begin
        s_axi_rdata <= {24'h0, way_disable};
      end else if (s_axi_araddr[3:0] == CBC_PID_ADDR) begin
        s_axi_rdata <= pid_reg;
      end else begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= CBC_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Strobe pin with one bus cycle breakpoint inversion
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      strobe_flip_reg <= 1'b0;
    end else if (brk_strobe_invert) begin
      strobe_flip_reg <= 1'b1;
    end else if (bus_clk_edge) begin
      strobe_flip_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      strobe_pin <= 1'b0;
    end else begin
      strobe_pin <= ctl_reg[CBC_STROBE_BIT] ^ strobe_flip_reg;
    end
  end

  // Steering of broadcast and cache machinery
  assign bus_broadcast_cache_op = cache_op_req &&
                                  !ctl_reg[CBC_CACHE_OFF_BIT];
  assign snoop_respond          = snoop_in_req &&
                                  !ctl_reg[CBC_CACHE_OFF_BIT];
  assign bus_broadcast_kill_bz  = blockzero_kill_req;
  assign bus_broadcast_barrier  = barrier_req &&
                                  !ctl_reg[CBC_BAR_OFF_BIT];
  assign barrier_local_done     = barrier_req &&
                                  ctl_reg[CBC_BAR_OFF_BIT];
  assign bus_broadcast_io_order = io_order_req &&
                                  !ctl_reg[CBC_IO_OFF_BIT];
  assign bus_broadcast_tlb      = (tlb_op_req || tlb_sync_req) &&
                                  !ctl_reg[CBC_XLAT_OFF_BIT];
  assign tlb_sync_local_done    = tlb_sync_req &&
                                  ctl_reg[CBC_XLAT_OFF_BIT];
  assign icache_use             = ctl_reg[CBC_ICACHE_BIT];
  assign icache_fill_allow      = ctl_reg[CBC_ICACHE_BIT];
  assign dcache_use             = ctl_reg[CBC_DCACHE_BIT];
  assign dcache_fill_allow      = ctl_reg[CBC_DCACHE_BIT];
  assign level2_use             = ctl_reg[CBC_L2_EN_BIT];
  assign instr_prefetch_go      = ifetch_miss && ctl_reg[CBC_L2_EN_BIT] &&
                                  ctl_reg[CBC_IPF_BIT];
  assign data_prefetch_go       = data_miss && ctl_reg[CBC_L2_EN_BIT] &&
                                  ctl_reg[CBC_DPF_BIT];
  assign block_valid_wr_allow   = diag_use_wr &&
                                  ctl_reg[CBC_TAG_UPD_BIT];
  assign instr_coherency_on     = ctl_reg[CBC_ICOH_BIT];

  always_comb begin
    way_count = 4'h0;
    for (int i = 0; i < CBC_WAYS; i++) begin
      way_count = way_count + {3'h0, way_disable[i]};
    end
  end

  assign way_check_risk = ctl_reg[CBC_L2_EN_BIT] &&
                          (way_count > 4'(CBC_WAY_LIMIT));

  // Checks
  way_guard_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    !ctl_reg[CBC_MASK_UPD_BIT] |=> $stable(way_disable))
    else $error("way disable changed while update locked");
  clk_ratio_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    !hard_reset |=> $stable(ctl_view[CBC_CLK_LSB +: CBC_CLK_W]))
    else $error("clock ratio changed without hard reset");
  strobe_copy_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    !strobe_flip_reg |=> strobe_pin == $past(ctl_reg[CBC_STROBE_BIT]))
    else $error("strobe pin does not follow strobe bit");
  bc_gate_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    ctl_reg[CBC_CACHE_OFF_BIT] |-> !bus_broadcast_cache_op && !snoop_respond)
    else $error("cache op broadcast while off");
  bz_kill_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    blockzero_kill_req |-> bus_broadcast_kill_bz)
    else $error("block zero kill suppressed");
  sync_local_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    barrier_req |-> (bus_broadcast_barrier != barrier_local_done))
    else $error("barrier both or neither broadcast and local");
  tlb_gate_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    ctl_reg[CBC_XLAT_OFF_BIT] |-> !bus_broadcast_tlb)
    else $error("translation op broadcast while off");
  io_gate_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    ctl_reg[CBC_IO_OFF_BIT] |-> !bus_broadcast_io_order)
    else $error("io ordering broadcast while off");
  resv_zero_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (ctl_reg & ~CBC_CTL_WMASK) == 32'h0)
    else $error("reserved control bits stored");
  pf_gate_a: assert property (
    @(posedge clk_sys) disable iff (reset)
    (instr_prefetch_go |-> ctl_reg[CBC_IPF_BIT]) and
    (data_prefetch_go |-> ctl_reg[CBC_DPF_BIT]))
    else $error("prefetch without enable");
endmodule : cbc_regs

//--- verif/cbc_regs_tb_top.sv
// Self-checking testbench for the cache and bus control register bank
`timescale 1ns/10ps
module cbc_regs_tb_top;
  import cbc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        hard_reset = 1'b1;
  logic [4:0]  cfg_pins = 5'h13;
  logic        bus_edge = 1'b0;
  logic        brk_inv = 1'b0;
  logic [10:0] req = '0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
  logic [3:0]  wstrb = '0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, strobe_pin, risk;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [16:0] st;
  logic [7:0]  way_dis;
  int          num_errors = 0;
  int          checks_done = 0;
  int          cyc = 0;
  logic [31:0] clk_f;
  cbc_regs u_cbc_regs (.clk_sys(clk_sys), .reset(reset),
    .hard_reset(hard_reset), .clock_cfg_pins(cfg_pins),
    .bus_clk_edge(bus_edge), .brk_strobe_invert(brk_inv),
    .blockzero_kill_req(req[0]), .cache_op_req(req[1]),
    .snoop_in_req(req[2]), .barrier_req(req[3]), .io_order_req(req[4]),
    .tlb_op_req(req[5]), .tlb_sync_req(req[6]), .diag_use_wr(req[7]),
    .ifetch_miss(req[8]), .data_miss(req[9]),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .strobe_pin(strobe_pin),
    .bus_broadcast_cache_op(st[16]), .snoop_respond(st[15]),
    .bus_broadcast_kill_bz(st[14]), .bus_broadcast_barrier(st[13]),
    .barrier_local_done(st[12]), .bus_broadcast_io_order(st[11]),
    .bus_broadcast_tlb(st[10]), .tlb_sync_local_done(st[9]),
    .icache_use(st[8]), .icache_fill_allow(st[7]), .dcache_use(st[6]),
    .dcache_fill_allow(st[5]), .level2_use(st[4]),
    .instr_prefetch_go(st[3]), .data_prefetch_go(st[2]),
    .block_valid_wr_allow(st[1]), .instr_coherency_on(st[0]),
    .way_disable(way_dis), .way_check_risk(risk));
  always #12.5 clk_sys = ~clk_sys;
  assign clk_f = {6'h00, cfg_pins, 21'h000000};
  task automatic end_sim;
    if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checks_done = checks_done + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  // Handshakes seen at negedge stand for the following rising edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic ah, wh, bh, ad, wd;
    ad = 0;
    wd = 0;
    bh = 0;
    @(posedge clk_sys);
    awaddr <= a; awvalid <= 1; wdata <= d; wstrb <= s; wvalid <= 1;
    bready <= 1;
    while (!bh) begin
      @(negedge clk_sys);
      ah = awvalid && awready === 1'b1;
      wh = wvalid && wready === 1'b1;
      bh = ad && wd && bvalid === 1'b1;
      @(posedge clk_sys);
      if (ah) begin awvalid <= 0; ad = 1; end
      if (wh) begin wvalid <= 0; wd = 1; end
    end
    bready <= 0;
    chk({30'h0, er}, {30'h0, bresp});
  endtask : wr
  // Handshake and read data sampled at negedge, acted on at next rise
  task automatic rd(input logic [31:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    logic        ah, an, rh;
    logic [31:0] d;
    logic [1:0]  r;
    ah = 0;
    rh = 0;
    d = '0;
    r = '0;
    @(posedge clk_sys);
    araddr <= a; arvalid <= 1; rready <= 1;
    while (!rh) begin
      @(negedge clk_sys);
      an = !ah && arvalid && arready === 1'b1;
      rh = ah && rvalid === 1'b1;
      d = rdata;
      r = rresp;
      @(posedge clk_sys);
      if (an) begin arvalid <= 0; ah = 1; end
    end
    rready <= 0;
    chk(ed, d);
    chk({30'h0, er}, {30'h0, r});
  endtask : rd
  function automatic logic [16:0] steer_exp(input logic [31:0] c);
    logic l2;
    l2 = c[CBC_L2_EN_BIT];
    steer_exp = {~c[CBC_CACHE_OFF_BIT], ~c[CBC_CACHE_OFF_BIT], 1'b1,
                 ~c[CBC_BAR_OFF_BIT], c[CBC_BAR_OFF_BIT],
                 ~c[CBC_IO_OFF_BIT], ~c[CBC_XLAT_OFF_BIT],
                 c[CBC_XLAT_OFF_BIT], {2{c[CBC_ICACHE_BIT]}},
                 {2{c[CBC_DCACHE_BIT]}}, l2, c[CBC_IPF_BIT] & l2,
                 c[CBC_DPF_BIT] & l2, c[CBC_TAG_UPD_BIT], c[CBC_ICOH_BIT]};
  endfunction : steer_exp
  task automatic t_reset_vals;
    rd(CBC_CTL_ADDR, clk_f, CBC_RESP_OKAY);
    rd(CBC_WAYD_ADDR, 32'h0, CBC_RESP_OKAY);
    rd(CBC_PID_ADDR, CBC_PID_RESET, CBC_RESP_OKAY);
  endtask : t_reset_vals
  // Every single bit, then all and none; requests held high
  task automatic t_steer;
    logic [31:0] v;
    logic [31:0] x;
    logic [16:0] e;
    req <= '1;
    for (int i = 0; i < 34; i++) begin
      v = (i < 32) ? (32'h1 << i) : ((i == 32) ? 32'hffff_ffff : 32'h0);
      x = clk_f | (v & CBC_CTL_WMASK);
      e = steer_exp(v & CBC_CTL_WMASK);
      wr(CBC_CTL_ADDR, v, 4'hf, CBC_RESP_OKAY);
      rd(CBC_CTL_ADDR, x, CBC_RESP_OKAY);
      chk(32'(e[16:15]), 32'(st[16:15]));
      chk(32'(e[14]), 32'(st[14]));
      chk(32'(e[13:12]), 32'(st[13:12]));
      chk(32'(e[11]), 32'(st[11]));
      chk(32'(e[10:9]), 32'(st[10:9]));
      chk(32'(e[8:7]), 32'(st[8:7]));
      chk(32'(e[6:5]), 32'(st[6:5]));
      chk(32'(e[4]), 32'(st[4]));
      chk(32'(e[3]), 32'(st[3]));
      chk(32'(e[2]), 32'(st[2]));
      chk(32'(e[1]), 32'(st[1]));
      chk(32'(e[0]), 32'(st[0]));
    end
    req <= '0;
    @(posedge clk_sys);
    chk(32'(st), 32'h0);
  endtask : t_steer
  // Way disable writes need mask update enable and byte lane 0; risk flag set above four ways with level 2 on
  task automatic t_way;
    logic [31:0] m;
    m = 32'h1 << CBC_MASK_UPD_BIT;
    wr(CBC_CTL_ADDR, 32'h0, 4'hf, CBC_RESP_OKAY);
    wr(CBC_WAYD_ADDR, 32'hff, 4'hf, CBC_RESP_OKAY);
    rd(CBC_WAYD_ADDR, 32'h0, CBC_RESP_OKAY);
    wr(CBC_CTL_ADDR, m, 4'hf, CBC_RESP_OKAY);
    wr(CBC_WAYD_ADDR, 32'hffff_ffff, 4'he, CBC_RESP_OKAY);
    rd(CBC_WAYD_ADDR, 32'h0, CBC_RESP_OKAY);
    wr(CBC_WAYD_ADDR, 32'hffff_ffff, 4'hf, CBC_RESP_OKAY);
    rd(CBC_WAYD_ADDR, 32'hff, CBC_RESP_OKAY);
    chk({31'h0, risk}, 32'h0);
    wr(CBC_CTL_ADDR, m | (32'h1 << CBC_L2_EN_BIT), 4'hf, CBC_RESP_OKAY);
    chk({24'h0, way_dis}, 32'hff);
    chk({31'h0, risk}, 32'h1);
    wr(CBC_WAYD_ADDR, 32'h0f, 4'hf, CBC_RESP_OKAY);
    chk({31'h0, risk}, 32'h0);
    wr(CBC_WAYD_ADDR, 32'h11, 4'hf, CBC_RESP_OKAY);
    chk({24'h0, way_dis}, 32'h11);
    wr(CBC_WAYD_ADDR, 32'h1f, 4'hf, CBC_RESP_OKAY);
    chk({31'h0, risk}, 32'h1);
    chk({24'h0, way_dis}, 32'h1f);
  endtask : t_way
  task automatic t_pid_bad;
    wr(CBC_PID_ADDR, 32'ha5c3_0f96, 4'hf, CBC_RESP_OKAY);
    wr(CBC_PID_ADDR, 32'h1234_7755, 4'h2, CBC_RESP_OKAY);
    rd(CBC_PID_ADDR, 32'ha5c3_7796, CBC_RESP_OKAY);
    wr(32'hc, 32'hffff_ffff, 4'hf, CBC_RESP_SLVERR);
    rd(32'hc, 32'h0, CBC_RESP_SLVERR);
    wr(32'h18, 32'h0, 4'hf, CBC_RESP_SLVERR);
    rd(32'h18, 32'h0, CBC_RESP_SLVERR);
    rd(CBC_PID_ADDR, 32'ha5c3_7796, CBC_RESP_OKAY);
  endtask : t_pid_bad
  task automatic t_strobe;
    wr(CBC_CTL_ADDR, 32'h1 << CBC_STROBE_BIT, 4'hf, CBC_RESP_OKAY);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, strobe_pin}, 32'h1);
    brk_inv <= 1;
    @(posedge clk_sys);
    brk_inv <= 0;
    repeat (3) @(posedge clk_sys);
    chk({31'h0, strobe_pin}, 32'h0);
    bus_edge <= 1;
    @(posedge clk_sys);
    bus_edge <= 0;
    repeat (3) @(posedge clk_sys);
    chk({31'h0, strobe_pin}, 32'h1);
    wr(CBC_CTL_ADDR, 32'h0, 4'hf, CBC_RESP_OKAY);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, strobe_pin}, 32'h0);
  endtask : t_strobe
  // Second hard reset loads a new clock ratio
  task automatic t_hard;
    cfg_pins <= 5'h0a;
    hard_reset <= 1;
    reset <= 1;
    repeat (2) @(posedge clk_sys);
    reset <= 0;
    hard_reset <= 0;
    rd(CBC_CTL_ADDR, {6'h00, 5'h0a, 21'h0}, CBC_RESP_OKAY);
    chk({24'h0, way_dis}, 32'h0);
  endtask : t_hard
  initial begin
    repeat (4) @(posedge clk_sys);
    reset <= 0;
    hard_reset <= 0;
    t_reset_vals();
    t_steer();
    t_way();
    t_pid_bad();
    t_strobe();
    t_hard();
    end_sim();
  end
endmodule : cbc_regs_tb_top
